//--- pkg/crc_ed_consts.svh
// timing counts, field widths, polynomials and codes for the frame crc checker
`ifndef CRC_ED_CONSTS_SVH
`define CRC_ED_CONSTS_SVH
`define ED_FRAMES 4
`define ED_FRAME_WORDS 4
`define ED_WORD_BITS 32
`define ED_FRAME_BITS 128
`define ED_LAST_BIT 8'h7f
`define ED_LAST_WORD 2'h3
`define ED_LAST_FRAME 2'h3
`define ED_POLY32 32'h04c1_1db7
`define ED_POLY16 16'h1021
`define ED_DIV_MAX 4'h8
`define ED_LOW_MIN 6'h20
`define ED_FLAG_HOLD 6'h20
`define ED_TYPE_NONE 4'h0
`define ED_TYPE_SINGLE 4'h1
`define ED_TYPE_DOUBLE 4'h2
`define ED_TYPE_OTHER 4'hf
`endif

//--- pkg/crc_ed_pkg.sv
// types shared by the frame crc checker and its bench
package crc_ed_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CALC = 3'b001,
    ST_CHECK = 3'b011,
    ST_LOCATE = 3'b010,
    ST_WAIT = 3'b110,
    ST_FLAG = 3'b111
  } scan_state_t;
  typedef struct packed {
    logic [3:0] etype;
    logic [9:0] byte_loc;
    logic [31:0] value;
  } inject_t;
  typedef struct packed {
    logic [14:0] frame;
    logic [15:0] bit_loc;
    logic [31:0] syndrome;
    logic [3:0] etype;
  } emr_t;
endpackage

//--- rtl/config_frame_crc_error_detect.sv
// frame crc checking at configuration time and background scanning in user mode
`timescale 1ns/10ps
`include "crc_ed_consts.svh"
module config_frame_crc_error_detect (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reconfig_request_n,
  input wire logic cfg_active,
  input wire logic cfg_word_valid,
  input wire logic [31:0] cfg_word,
  input wire logic [15:0] cfg_check16,
  input wire logic [31:0] cfg_ref32,
  input wire logic ed_enable,
  input wire logic [3:0] div_exp,
  input wire logic inj_valid,
  input wire crc_ed_pkg::inject_t inj,
  output logic config_status_n,
  output logic crc_error,
  output crc_ed_pkg::emr_t error_message_reg,
  output logic [31:0] syndrome
);
  import crc_ed_pkg::*;

  // ==========================================
  // crc functions
  function automatic logic [31:0] crc32_word(input logic [31:0] c, input logic [31:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[30:0], 1'b0} ^ ((r[31] ^ d[i]) ? `ED_POLY32 : 32'h0000_0000);
    end
    return r;
  endfunction

  function automatic logic [15:0] crc16_word(input logic [15:0] c, input logic [31:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? `ED_POLY16 : 16'h0000);
    end
    return r;
  endfunction

  // one zero-input shift: next power of x for single-bit syndromes
  function automatic logic [31:0] xshift(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? `ED_POLY32 : 32'h0000_0000);
  endfunction

  // ==========================================
  // storage of configured frames
  logic [31:0] cells [`ED_FRAMES*`ED_FRAME_WORDS];
  logic [31:0] ref_mem [`ED_FRAMES];
  logic [1:0] cfg_word_r, cfg_frame_r;
  logic [15:0] cfg_crc_r;
  logic config_status_n_r;
  wire cfg_take = cfg_active && cfg_word_valid;
  wire cfg_last = cfg_word_r == `ED_LAST_WORD;
  wire [15:0] cfg_crc_nxt = crc16_word(cfg_crc_r, cfg_word);
  wire cfg_bad = cfg_take && cfg_last && (cfg_crc_nxt != cfg_check16);
  // injection targets the first frame only; ignored while loading
  wire inj_take = inj_valid && !cfg_active && (inj.etype != `ED_TYPE_NONE);
  wire [3:0] inj_idx = {2'b00, inj.byte_loc[3:2]};

  always_ff @(posedge clk) begin
    if (cfg_take) begin
      cells[{cfg_frame_r, cfg_word_r}] <= cfg_word;
      if (cfg_last) begin
        ref_mem[cfg_frame_r] <= cfg_ref32;
      end
    end else if (inj_take) begin
      cells[inj_idx] <= cells[inj_idx] ^ inj.value;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !reconfig_request_n) begin
      cfg_word_r <= 2'h0;
      cfg_frame_r <= 2'h0;
      cfg_crc_r <= 16'h0000;
      config_status_n_r <= 1'b1;
    end else if (cfg_take) begin
      cfg_word_r <= cfg_word_r + 2'h1;
      cfg_frame_r <= cfg_last ? cfg_frame_r + 2'h1 : cfg_frame_r;
      cfg_crc_r <= cfg_last ? 16'h0000 : cfg_crc_nxt;
      if (cfg_bad) begin
        config_status_n_r <= 1'b0;
      end
    end
  end

  // ==========================================
  // check clock divider
  logic [8:0] div_cnt_r;
  wire [3:0] eff_n = (div_exp > `ED_DIV_MAX) ? `ED_DIV_MAX : div_exp;
  wire [8:0] div_lim = (9'h001 << eff_n) - 9'h001;
  wire tick = div_cnt_r >= div_lim;
  wire run = ed_enable && !cfg_active && reconfig_request_n;

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      div_cnt_r <= 9'h000;
    end else begin
      div_cnt_r <= tick ? 9'h000 : div_cnt_r + 9'h001;
    end
  end

  // ==========================================
  // background scan
  scan_state_t state_r, state_nxt;
  logic [1:0] frame_r, word_r;
  logic [31:0] crc_r, pow_r, syndrome_r;
  logic [7:0] k_r;
  logic [5:0] low_cnt_r, hold_r;
  logic crc_error_r;
  emr_t emr_r, emr_nxt;

  wire [31:0] rd_word = cells[{frame_r, word_r}];
  wire [31:0] crc_nxt = crc32_word(crc_r, rd_word);
  wire [31:0] syn_calc = crc_r ^ ref_mem[frame_r];
  wire [31:0] pow_nxt = xshift(pow_r);
  wire hit_single = syndrome_r == pow_r;
  wire hit_double = (k_r != `ED_LAST_BIT) && (syndrome_r == (pow_r ^ pow_nxt));
  wire search_end = k_r == `ED_LAST_BIT;
  wire low_done = low_cnt_r >= `ED_LOW_MIN;
  wire [7:0] loc_single = `ED_LAST_BIT - k_r;
  wire [7:0] loc_double = loc_single - 8'h01;

  always_comb begin
    emr_nxt = emr_r;
    emr_nxt.frame = {13'h0000, frame_r};
    emr_nxt.syndrome = syndrome_r;
    if (hit_single) begin
      emr_nxt.etype = `ED_TYPE_SINGLE;
      emr_nxt.bit_loc = {8'h00, loc_single};
    end else if (hit_double) begin
      emr_nxt.etype = `ED_TYPE_DOUBLE;
      emr_nxt.bit_loc = {8'h00, loc_double};
    end else begin
      emr_nxt.etype = `ED_TYPE_OTHER;
      emr_nxt.bit_loc = 16'h0000;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = ST_CALC;
      ST_CALC: state_nxt = (tick && word_r == `ED_LAST_WORD) ? ST_CHECK : ST_CALC;
      ST_CHECK: state_nxt = !tick ? ST_CHECK : (syn_calc == 32'h0000_0000) ? ST_CALC : ST_LOCATE;
      ST_LOCATE: state_nxt = (tick && (hit_single || hit_double || search_end)) ? ST_WAIT : ST_LOCATE;
      ST_WAIT: state_nxt = (tick && low_done) ? ST_FLAG : ST_WAIT;
      ST_FLAG: state_nxt = (tick && hold_r >= `ED_FLAG_HOLD) ? ST_CALC : ST_FLAG;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !run || state_r == ST_IDLE) begin
      frame_r <= 2'h0;
      word_r <= 2'h0;
      crc_r <= 32'h0000_0000;
      low_cnt_r <= 6'h00;
    end else if (tick) begin
      word_r <= (state_r == ST_CALC) ? word_r + 2'h1 : word_r;
      crc_r <= (state_r == ST_CALC) ? crc_nxt : (state_nxt == ST_CALC) ? 32'h0000_0000 : crc_r;
      frame_r <= (state_r != ST_CALC && state_nxt == ST_CALC) ? frame_r + 2'h1 : frame_r;
      low_cnt_r <= (state_r != ST_CALC && state_nxt == ST_CALC) ? 6'h00 :
                   low_done ? low_cnt_r : low_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      syndrome_r <= 32'h0000_0000;
    end else if (state_r == ST_CHECK && tick) begin
      syndrome_r <= syn_calc;
    end
  end

  always_ff @(posedge clk) begin
    if (state_r == ST_CHECK) begin
      // a lone flip meets 32 more shifts than its own offset, so the search starts at x^32
      pow_r <= `ED_POLY32;
      k_r <= 8'h00;
    end else if (state_r == ST_LOCATE && tick) begin
      pow_r <= pow_nxt;
      k_r <= k_r + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      emr_r <= '0;
    end else if (state_r == ST_LOCATE && state_nxt == ST_WAIT) begin
      emr_r <= emr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      crc_error_r <= 1'b0;
      hold_r <= 6'h00;
    end else begin
      crc_error_r <= state_nxt == ST_FLAG;
      hold_r <= (state_r != ST_FLAG) ? 6'h00 : (tick ? hold_r + 6'h01 : hold_r);
    end
  end

  assign config_status_n = config_status_n_r;
  assign crc_error = crc_error_r;
  assign error_message_reg = emr_r;
  assign syndrome = syndrome_r;

  // ==========================================
  // assertions
  sequence flag_cause_s;
    state_r == ST_WAIT && tick && low_done;
  endsequence
  sequence flag_shown_s;
    crc_error ##1 crc_error;
  endsequence

  cfg_mismatch_a: assert property (@(posedge clk) disable iff (!reset_n)
    cfg_bad && reconfig_request_n |=> !config_status_n) else $error("config mismatch not reported");
  scan_disabled_a: assert property (@(posedge clk) disable iff (!reset_n)
    !ed_enable |=> state_r == ST_IDLE && !crc_error) else $error("scan ran while disabled");
  match_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_r == ST_CHECK && tick && syn_calc == 32'h0000_0000 |=> syndrome == 32'h0000_0000)
    else $error("syndrome not cleared on match");
  mismatch_flag_a: assert property (@(posedge clk) disable iff (!reset_n || !run)
    flag_cause_s |=> flag_shown_s) else $error("error flag not raised");
  flag_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    $rose(crc_error) |-> low_cnt_r == `ED_LOW_MIN) else $error("flag rose too early");
  div_two_a: assert property (@(posedge clk) disable iff (!reset_n || !run)
    tick && eff_n == 4'h1 && $stable(div_exp) |=> !tick ##1 tick) else $error("divide by two wrong");
  emr_type_a: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(error_message_reg) |-> error_message_reg.etype inside {`ED_TYPE_SINGLE, `ED_TYPE_DOUBLE,
    `ED_TYPE_OTHER}) else $error("bad error type");
  reconfig_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
    !reconfig_request_n |=> state_r == ST_IDLE && config_status_n) else $error("reconfig did not reset");
endmodule // config_frame_crc_error_detect

//--- sim/config_frame_crc_error_detect_tb_top.sv
// self-checking bench for the frame crc checker
`timescale 1ns/10ps
`include "crc_ed_consts.svh"
module config_frame_crc_error_detect_tb_top;
  import crc_ed_pkg::*;
  logic clk, reset_n, reconfig_request_n, ed_enable, inj_valid;
  logic cfg_active, cfg_word_valid, config_status_n, crc_error;
  logic [31:0] cfg_word, cfg_ref32, syndrome;
  logic [15:0] cfg_check16;
  logic [3:0] div_exp;
  inject_t inj;
  emr_t error_message_reg;
  int fail_count, check_count, cyc, t0, t2;
  // rows: bad flag, bad frame[2:1], expected status
  logic [3:0] rows [4] = '{4'b0001, 4'b1000, 4'b1110, 4'b0101};
  frame_loader ldr (.clk(clk), .cfg_active(cfg_active), .cfg_word_valid(cfg_word_valid), .cfg_word(cfg_word),
    .cfg_check16(cfg_check16), .cfg_ref32(cfg_ref32));
  config_frame_crc_error_detect dut (.clk(clk), .reset_n(reset_n), .reconfig_request_n(reconfig_request_n),
    .cfg_active(cfg_active), .cfg_word_valid(cfg_word_valid), .cfg_word(cfg_word), .cfg_check16(cfg_check16),
    .cfg_ref32(cfg_ref32), .ed_enable(ed_enable), .div_exp(div_exp), .inj_valid(inj_valid), .inj(inj),
    .config_status_n(config_status_n), .crc_error(crc_error), .error_message_reg(error_message_reg),
    .syndrome(syndrome));
  // ==========
  // shared tasks
  task automatic final_report();
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [66:0] got, input logic [66:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_lvl(input logic lvl, input int lim, output int t);
    t = 0;
    while (crc_error !== lvl && t < lim) begin
      @(negedge clk);
      t++;
    end
  endtask
  task automatic reconfig();
    ed_enable = 1'b0;
    reconfig_request_n = 1'b0;
    repeat (2) @(negedge clk);
    reconfig_request_n = 1'b1;
  endtask
  task automatic scan(input logic [31:0] v, input logic [3:0] et, input logic [3:0] n, input logic [15:0] loc,
    output int t);
    int t_next;
    reconfig();
    ldr.load(2'h0, 1'b0);
    div_exp = n;
    if (et != `ED_TYPE_NONE) begin
      inj = '{et, 10'h000, v};
      inj_valid = 1'b1;
      @(negedge clk);
      inj_valid = 1'b0;
    end
    ed_enable = 1'b1;
    if (et == `ED_TYPE_NONE) begin
      wait_lvl(1'b1, 2000, t);
      chk(crc_error, 1'b0);
      chk(syndrome, 32'h0000_0000);
    end else begin
      wait_lvl(1'b1, 20000, t);
      chk(crc_error, 1'b1);
      chk(t >= (32 << n), 1'b1);
      chk(error_message_reg.etype, et);
      chk(error_message_reg.bit_loc, loc);
      chk(error_message_reg.frame, 15'h0000);
      chk(error_message_reg.syndrome, syndrome);
      chk(syndrome != 32'h0000_0000, 1'b1);
      wait_lvl(1'b0, 20000, t_next);
      wait_lvl(1'b1, 20000, t_next);
      chk(crc_error, 1'b1);
    end
    ed_enable = 1'b0;
    repeat (2) @(negedge clk);
    chk(crc_error, 1'b0);
  endtask
  // ==========
  // clock, timeout, main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ceiling well above the longest scan sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      final_report();
    end
  end
  initial begin
    reset_n = 1'b0;
    reconfig_request_n = 1'b1;
    ed_enable = 1'b0;
    div_exp = 4'h0;
    inj_valid = 1'b0;
    inj = '0;
    repeat (8) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    chk({config_status_n, crc_error, syndrome}, {1'b1, 1'b0, 32'h0000_0000});
    chk(error_message_reg, 67'h0);
    for (int i = 0; i < 4; i++) begin
      reconfig();
      ldr.load(rows[i][2:1], rows[i][3]);
      repeat (2) @(negedge clk);
      chk(config_status_n, rows[i][0]);
    end
    scan(32'h0000_0000, `ED_TYPE_NONE, 4'h1, 16'h0000, t0);
    scan(32'h0000_0001, `ED_TYPE_SINGLE, 4'h0, 16'h001f, t0);
    scan(32'h0000_0300, `ED_TYPE_DOUBLE, 4'h2, 16'h0016, t2);
    chk(t2 > 3 * t0, 1'b1);
    final_report();
  end
endmodule // config_frame_crc_error_detect_tb_top

//--- sim/frame_loader.sv
// configuration frame source: loads stored frames with their 16-bit and 32-bit check values
`timescale 1ns/10ps
`include "crc_ed_consts.svh"
module frame_loader (
  input wire logic clk,
  output logic cfg_active,
  output logic cfg_word_valid,
  output logic [31:0] cfg_word,
  output logic [15:0] cfg_check16,
  output logic [31:0] cfg_ref32
);
  // ==========
  // serial crc, init 0, frame bit 0 is word0 msb
  function automatic logic [31:0] crc(input logic [127:0] d, input logic [31:0] poly, input int w);
    logic [31:0] c;
    c = 32'h0000_0000;
    for (int i = 127; i >= 0; i--) begin
      c = ((c << 1) ^ ((c[w-1] ^ d[i]) ? poly : 32'h0000_0000)) & ((32'h0000_0001 << w) - 1);
    end
    return c;
  endfunction
  initial begin
    cfg_active = 1'b0;
    cfg_word_valid = 1'b0;
    cfg_word = 32'h0000_0000;
    cfg_check16 = 16'h0000;
    cfg_ref32 = 32'h0000_0000;
  end
  // ==========
  // one full load, optionally with a wrong check value on one frame
  task automatic load(input logic [1:0] bad_frame, input logic bad);
    logic [127:0] d;
    for (int f = 0; f < `ED_FRAMES; f++) begin
      d = {32'h1357_9bdf ^ f, 32'h2468_ace0 ^ f, 32'h0f0f_5a5a ^ f, 32'hc3c3_0000 ^ f};
      for (int w = 0; w < `ED_FRAME_WORDS; w++) begin
        @(negedge clk);
        cfg_active = 1'b1;
        cfg_word_valid = 1'b1;
        cfg_word = d[127-32*w -: 32];
        cfg_check16 = 16'(crc(d, 32'(`ED_POLY16), 16)) ^ {15'h0000, bad && (f == bad_frame)};
        cfg_ref32 = crc(d, `ED_POLY32, 32);
      end
    end
    @(negedge clk);
    cfg_word_valid = 1'b0;
    // released data lines do not keep the last value
    cfg_word = ~cfg_word;
    cfg_check16 = ~cfg_check16;
    cfg_ref32 = ~cfg_ref32;
    @(negedge clk);
    cfg_active = 1'b0;
  endtask
endmodule // frame_loader
